// ==== ibc_pkg.sv ====
// Constants, types and state codes for the two-wire master with stop collision check.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
// Function
// - After SDA release and counter expiry, low SDA means bus collision.
// - After SCL release, SCL low before SDA rises means bus collision.
// - Stop begins with SDA driven low; SCL released once SDA reads low.
// - Once SCL reads high, load counter from reload register and count down.
// - Bit-rate counter clocks both two-wire master and SPI master modes.
// - Serial clock equals oscillator over four times reload plus one.
// - Writing the shift buffer starts the counter counting down.
// - Counter stops when operation ends; clock pin keeps its last level.
// - Counter reloads twice per serial clock period, timed by the mode.
// - On collision set collision flag and return port to idle.
// - Collision aborts sequences, releases both lines, clears request bits.
// - Clean stop: flag stop seen, one period later clear request, set event.
`default_nettype none
package ibc_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTL1   = 8'h04;
   localparam logic [7:0] ADDR_CTL2   = 8'h08;
   localparam logic [7:0] ADDR_CTL3   = 8'h0c;
   localparam logic [7:0] ADDR_RELOAD = 8'h10;
   localparam logic [7:0] ADDR_BUF    = 8'h14;
   localparam logic [7:0] ADDR_MASK   = 8'h18;
   localparam logic [7:0] ADDR_FLAGS  = 8'h1c;
   localparam logic [7:0] RST_VAL     = 8'h00;
   ////////////////////////////////////////////////////////////////////////////
   localparam int STAT_STOP_BIT = 4;
   localparam int STAT_TX_BIT   = 2;
   localparam int STAT_BF_BIT   = 0;
   localparam int CTL1_EN_BIT   = 5;
   localparam int CTL2_STOP_BIT = 2;
   localparam int FLAG_COLL_BIT = 0;
   localparam int FLAG_PORT_BIT = 1;
   localparam int FLAG_WCOL_BIT = 2;
   localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
   localparam logic [3:0] MODE_SPI_MASTER = 4'ha;
   // Oscillator clocks per counter step
   localparam logic [1:0] TICK_DIV = 2'h2;
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_SDA_LOW = 3'b001,
      ST_SCL_REL = 3'b010,
      ST_HOLD    = 3'b011,
      ST_SDA_REL = 3'b100,
      ST_FIN     = 3'b101,
      ST_XFER    = 3'b110
   } ibc_state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } ibc_pins_t;
endpackage
`default_nettype wire

// ==== ibc_master.sv ====
// Two-wire / SPI master core: bit-rate counter, byte shifter and stop sequencer.
// Assumes pins are open-drain in two-wire mode and inputs are already synchronous.
//
// Decided for this implementation: the APB register port and the register addresses.
`default_nettype none
module ibc_master #(
   parameter int DATA_W    = 8,
   parameter int BUF_DEPTH = 2
) (
   input  wire logic        clk_i,     // Oscillator clock
   input  wire logic        rst_i,     // Async reset, high
   input  wire logic        psel_i,    // APB select
   input  wire logic        penable_i, // APB enable
   input  wire logic        pwrite_i,  // APB write
   input  wire logic [7:0]  paddr_i,   // APB byte address
   input  wire logic [31:0] pwdata_i,  // APB write data
   output logic      [31:0] prdata_o,  // APB read data
   output logic             pready_o,  // APB ready
   output logic             pslverr_o, // APB error, unmapped
   input  wire logic        scl_i,     // Clock pin level
   output logic             scl_o,     // Clock pin drive value
   output logic             scl_oe_o,  // Clock pin drive enable
   input  wire logic        sda_i,     // Data pin level
   output logic             sda_o,     // Data pin drive value
   output logic             sda_oe_o   // Data pin drive enable
);
   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int HB_W  = $clog2(2 * DATA_W) + 1;
   localparam logic [HB_W-1:0] HALVES = HB_W'(2 * DATA_W);

   function automatic logic addr_known(input logic [7:0] a);
      case (a)
         ibc_pkg::ADDR_STATUS, ibc_pkg::ADDR_CTL1, ibc_pkg::ADDR_CTL2,
         ibc_pkg::ADDR_CTL3, ibc_pkg::ADDR_RELOAD, ibc_pkg::ADDR_BUF,
         ibc_pkg::ADDR_MASK, ibc_pkg::ADDR_FLAGS: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(BUF_DEPTH - 1)) ? '0 : p + PTR_W'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] pre, next_pre;
   logic       tick;
   assign tick = (pre == ibc_pkg::TICK_DIV - 2'h1);
   always_comb
   begin
      next_pre = tick ? 2'h0 : pre + 2'h1;
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i) pre <= 2'h0;
      else       pre <= next_pre;
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] ctl1, ctl2, ctl3, reload, mask, flags, next_ctl1, next_ctl2;
   logic [7:0] next_ctl3, next_reload, next_mask, next_flags, rd_mux;
   logic [31:0] next_prdata;
   logic       stop_seen, next_stop_seen, access, wr_en, stop_busy, buf_wr;
   logic       en, i2c_mode, spi_mode, coll, stop_done, stop_det, wcol, pop;
   logic       buf_valid, buf_ready;
   logic [DATA_W-1:0] buf_data, shreg;
   ibc_pkg::ibc_state_t state, next_state;

   assign en        = ctl1[ibc_pkg::CTL1_EN_BIT];
   assign i2c_mode  = en && ctl1[3:0] == ibc_pkg::MODE_I2C_MASTER;
   assign spi_mode  = en && ctl1[3:0] == ibc_pkg::MODE_SPI_MASTER;
   assign access    = psel_i && penable_i;
   assign stop_busy = ctl2[ibc_pkg::CTL2_STOP_BIT]
                      || (state != ibc_pkg::ST_IDLE && state != ibc_pkg::ST_XFER);
   assign buf_wr    = access && pwrite_i && paddr_i == ibc_pkg::ADDR_BUF;
   // A buffer write while full and no stop is busy stalls the bus until the shifter drains a word
   assign pready_o  = !(buf_wr && !stop_busy && !buf_ready);
   assign pslverr_o = access && !addr_known(paddr_i);
   assign wr_en     = access && pwrite_i && pready_o && addr_known(paddr_i);
   assign wcol      = wr_en && buf_wr && stop_busy;

   always_comb
   begin
      rd_mux = 8'h00;
      unique case (paddr_i)
         ibc_pkg::ADDR_STATUS:
         begin
            rd_mux[ibc_pkg::STAT_STOP_BIT] = stop_seen;
            rd_mux[ibc_pkg::STAT_TX_BIT]   = (state == ibc_pkg::ST_XFER);
            rd_mux[ibc_pkg::STAT_BF_BIT]   = buf_valid;
         end
         ibc_pkg::ADDR_CTL1:   rd_mux = ctl1;
         ibc_pkg::ADDR_CTL2:   rd_mux = ctl2;
         ibc_pkg::ADDR_CTL3:   rd_mux = ctl3;
         ibc_pkg::ADDR_RELOAD: rd_mux = reload;
         ibc_pkg::ADDR_BUF:    rd_mux = 8'(shreg);
         ibc_pkg::ADDR_MASK:   rd_mux = mask;
         ibc_pkg::ADDR_FLAGS:  rd_mux = flags;
         default:              rd_mux = 8'h00;
      endcase
      // Read data is captured in the setup cycle and shown in the access cycle
      next_prdata = (psel_i && !penable_i) ? {24'h000000, rd_mux} : prdata_o;
      next_ctl1   = (wr_en && paddr_i == ibc_pkg::ADDR_CTL1) ? pwdata_i[7:0] : ctl1;
      next_ctl2   = (wr_en && paddr_i == ibc_pkg::ADDR_CTL2) ? pwdata_i[7:0] : ctl2;
      next_ctl3   = (wr_en && paddr_i == ibc_pkg::ADDR_CTL3) ? pwdata_i[7:0] : ctl3;
      next_reload = (wr_en && paddr_i == ibc_pkg::ADDR_RELOAD) ? pwdata_i[7:0] : reload;
      next_mask   = (wr_en && paddr_i == ibc_pkg::ADDR_MASK) ? pwdata_i[7:0] : mask;
      if (coll || stop_done)
         next_ctl2[ibc_pkg::CTL2_STOP_BIT] = 1'b0;
      next_flags = flags;
      if (wr_en && paddr_i == ibc_pkg::ADDR_FLAGS)
         next_flags = flags & ~pwdata_i[7:0];
      // Hardware sets win over a clear in the same cycle
      if (coll)
         next_flags[ibc_pkg::FLAG_COLL_BIT] = 1'b1;
      if (stop_done)
         next_flags[ibc_pkg::FLAG_PORT_BIT] = 1'b1;
      if (wcol)
         next_flags[ibc_pkg::FLAG_WCOL_BIT] = 1'b1;
      next_stop_seen = stop_seen;
      if (!en || pop)
         next_stop_seen = 1'b0;
      if (stop_det)
         next_stop_seen = 1'b1;
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         prdata_o  <= 32'h00000000;
         ctl1      <= ibc_pkg::RST_VAL;
         ctl2      <= ibc_pkg::RST_VAL;
         ctl3      <= ibc_pkg::RST_VAL;
         reload    <= ibc_pkg::RST_VAL;
         mask      <= ibc_pkg::RST_VAL;
         flags     <= ibc_pkg::RST_VAL;
         stop_seen <= 1'b0;
      end
      else
      begin
         prdata_o  <= next_prdata;
         ctl1      <= next_ctl1;
         ctl2      <= next_ctl2;
         ctl3      <= next_ctl3;
         reload    <= next_reload;
         mask      <= next_mask;
         flags     <= next_flags;
         stop_seen <= next_stop_seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [DATA_W-1:0] mem [BUF_DEPTH];
   logic [DATA_W-1:0] next_mem [BUF_DEPTH];
   logic [PTR_W-1:0]  wptr, rptr, next_wptr, next_rptr;
   logic [PTR_W:0]    fill, next_fill;
   logic              push;

   assign buf_valid = (fill != '0);
   assign buf_ready = (fill != (PTR_W + 1)'(BUF_DEPTH));
   assign buf_data  = mem[rptr];
   assign push      = wr_en && buf_wr && !stop_busy;
   assign pop       = buf_valid && state == ibc_pkg::ST_IDLE
                      && (i2c_mode || spi_mode) && !ctl2[ibc_pkg::CTL2_STOP_BIT];
   always_comb
   begin
      next_mem  = mem;
      next_wptr = wptr;
      next_rptr = rptr;
      next_fill = fill;
      if (push)
      begin
         next_mem[wptr] = pwdata_i[DATA_W-1:0];
         next_wptr      = ptr_inc(wptr);
      end
      if (pop)
         next_rptr = ptr_inc(rptr);
      next_fill = fill + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < BUF_DEPTH; i++) mem[i] <= '0;
         wptr <= '0;
         rptr <= '0;
         fill <= '0;
      end
      else
      begin
         mem  <= next_mem;
         wptr <= next_wptr;
         rptr <= next_rptr;
         fill <= next_fill;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]        cnt, next_cnt;
   logic [HB_W-1:0]   halves, next_halves;
   logic [DATA_W-1:0] next_shreg;
   ibc_pkg::ibc_pins_t lvl, next_lvl;
   logic              load, expire;

   assign expire = tick && cnt == 8'h00 && state != ibc_pkg::ST_IDLE;
   always_comb
   begin
      next_state  = state;
      next_lvl    = lvl;
      next_shreg  = shreg;
      next_halves = halves;
      load        = 1'b0;
      coll        = 1'b0;
      stop_det    = 1'b0;
      stop_done   = 1'b0;
      unique case (state)
         ibc_pkg::ST_IDLE:
            if (i2c_mode && ctl2[ibc_pkg::CTL2_STOP_BIT])
            begin
               next_lvl.sda = 1'b0;
               next_state   = ibc_pkg::ST_SDA_LOW;
            end
            else if (pop)
            begin
               load        = 1'b1;
               next_shreg  = buf_data;
               next_halves = '0;
               next_lvl    = '{scl: 1'b0, sda: buf_data[DATA_W-1]};
               next_state  = ibc_pkg::ST_XFER;
            end
         ibc_pkg::ST_XFER:
            if (expire)
            begin
               load         = 1'b1;
               next_lvl.scl = !lvl.scl;
               next_halves  = halves + HB_W'(1);
               if (lvl.scl)
               begin
                  next_shreg   = shreg << 1;
                  next_lvl.sda = shreg[DATA_W-2];
               end
               // Clock pin then keeps its last level until the next operation
               if (next_halves == HALVES)
                  next_state = ibc_pkg::ST_IDLE;
            end
         ibc_pkg::ST_SDA_LOW:
            if (!sda_i)
            begin
               next_lvl.scl = 1'b1;
               next_state   = ibc_pkg::ST_SCL_REL;
            end
         ibc_pkg::ST_SCL_REL:
            // Waits out a slave that stretches the clock
            if (scl_i)
            begin
               load       = 1'b1;
               next_state = ibc_pkg::ST_HOLD;
            end
         ibc_pkg::ST_HOLD:
            if (!scl_i)
               coll = 1'b1;
            else if (expire)
            begin
               load         = 1'b1;
               next_lvl.sda = 1'b1;
               next_state   = ibc_pkg::ST_SDA_REL;
            end
         ibc_pkg::ST_SDA_REL:
            if (!scl_i && !sda_i)
               coll = 1'b1;
            else if (expire)
            begin
               if (!sda_i)
                  coll = 1'b1;
               else if (scl_i)
               begin
                  stop_det   = 1'b1;
                  load       = 1'b1;
                  next_state = ibc_pkg::ST_FIN;
               end
            end
         ibc_pkg::ST_FIN:
            if (expire)
            begin
               stop_done  = 1'b1;
               next_state = ibc_pkg::ST_IDLE;
            end
         default: next_state = ibc_pkg::ST_IDLE;
      endcase
      if (coll)
      begin
         next_lvl   = '{scl: 1'b1, sda: 1'b1};
         next_state = ibc_pkg::ST_IDLE;
      end
      if (!en)
      begin
         next_lvl   = '{scl: 1'b1, sda: 1'b1};
         next_state = ibc_pkg::ST_IDLE;
      end
      next_cnt = cnt;
      if (load)
         next_cnt = reload;
      else if (tick && cnt != 8'h00 && state != ibc_pkg::ST_IDLE)
         next_cnt = cnt - 8'h01;
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state  <= ibc_pkg::ST_IDLE;
         lvl    <= '{scl: 1'b1, sda: 1'b1};
         shreg  <= '0;
         halves <= '0;
         cnt    <= 8'h00;
      end
      else
      begin
         state  <= next_state;
         lvl    <= next_lvl;
         shreg  <= next_shreg;
         halves <= next_halves;
         cnt    <= next_cnt;
      end
   end

   // Open drain in two-wire mode, push-pull in SPI mode
   assign scl_o    = spi_mode ? lvl.scl : 1'b0;
   assign sda_o    = spi_mode ? lvl.sda : 1'b0;
   assign scl_oe_o = spi_mode || (en && !lvl.scl);
   assign sda_oe_o = spi_mode || (en && !lvl.sda);

   ////////////////////////////////////////////////////////////////////////////
   logic [9:0] gap;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)                gap <= 10'h001;
      else if (lvl.scl != next_lvl.scl) gap <= 10'h001;
      else                      gap <= gap + 10'h001;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_stop_ok;
      state == ibc_pkg::ST_SDA_REL && expire && sda_i && scl_i;
   endsequence

   a_sda_before_scl: assert property (
      (state == ibc_pkg::ST_SDA_LOW && !sda_i && en)
      |=> state == ibc_pkg::ST_SCL_REL && lvl.scl && !lvl.sda)
      else $error("clock not released after data went low");
   a_load_on_scl: assert property (
      (state == ibc_pkg::ST_SCL_REL && scl_i && en)
      |=> cnt == reload && state == ibc_pkg::ST_HOLD)
      else $error("counter not loaded after clock went high");
   a_sda_low_coll: assert property (
      (state == ibc_pkg::ST_SDA_REL && expire && !sda_i && en)
      |=> flags[ibc_pkg::FLAG_COLL_BIT] && state == ibc_pkg::ST_IDLE)
      else $error("low data after expiry not flagged");
   a_scl_low_coll: assert property (
      (state == ibc_pkg::ST_HOLD && !scl_i && en)
      |=> flags[ibc_pkg::FLAG_COLL_BIT] && !ctl2[ibc_pkg::CTL2_STOP_BIT])
      else $error("early clock low not flagged");
   a_coll_release: assert property (
      coll |=> lvl.scl && lvl.sda && state == ibc_pkg::ST_IDLE)
      else $error("lines not released after collision");
   a_stop_clean: assert property (
      s_stop_ok ##1 (state == ibc_pkg::ST_FIN && en) [*1] |-> stop_seen)
      else $error("stop not recorded");
   a_stop_finish: assert property (
      (state == ibc_pkg::ST_FIN && expire && en)
      |=> flags[ibc_pkg::FLAG_PORT_BIT] && !ctl2[ibc_pkg::CTL2_STOP_BIT]
         && state == ibc_pkg::ST_IDLE)
      else $error("stop end not signalled");
   a_half_period: assert property (
      (state == ibc_pkg::ST_XFER && halves != '0 && lvl.scl != next_lvl.scl && en)
      |-> gap == {1'b0, reload, 1'b0} + 10'h002)
      else $error("half period length wrong");
   a_reload_twice: assert property (
      (state == ibc_pkg::ST_XFER && expire && en) |=> cnt == reload)
      else $error("counter not reloaded at half period");
   a_buf_start: assert property (
      (pop && en) |=> state == ibc_pkg::ST_XFER && cnt == reload)
      else $error("buffer word did not start counter");
   a_idle_frozen: assert property (
      (state == ibc_pkg::ST_IDLE) |=> $stable(cnt) && $stable(lvl.scl) || !en || $past(pop)
         || $past(coll) || state != ibc_pkg::ST_IDLE)
      else $error("counter or clock moved while idle");
   a_tick_rate: assert property (
      tick |=> !tick ##1 tick)
      else $error("counter step rate wrong");
endmodule
`default_nettype wire

// ==== ibc_peer.sv ====
// Far side of the shared two-wire bus: pull-ups plus another party that can
// stretch the clock, hold data low, or pull the clock low in mid-stop.
// Assumes the master drives only through its enables and runs on clk_i.
`default_nettype none
module ibc_peer (
   input  wire logic clk_i,      // Bench clock
   input  wire logic rst_i,      // Async reset, high
   input  wire logic scl_d_i,    // Master clock drive value
   input  wire logic scl_oe_i,   // Master clock drive enable
   input  wire logic sda_d_i,    // Master data drive value
   input  wire logic sda_oe_i,   // Master data drive enable
   input  wire logic hold_scl_i, // Keep clock low (stretch)
   input  wire logic hold_sda_i, // Keep data low
   input  wire logic bump_scl_i, // Pull clock low once it sat high
   output logic      scl_o,      // Resolved clock line
   output logic      sda_o       // Resolved data line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] high_cnt;
   logic       bump;
   logic [1:0] next_high_cnt;
   logic       next_bump;
   ////////////////////////////////////////////////////////////////////////////
   // Released lines float high through the pull-ups; any low wins
   assign scl_o = (scl_oe_i ? scl_d_i : 1'b1) & ~hold_scl_i & ~bump;
   assign sda_o = (sda_oe_i ? sda_d_i : 1'b1) & ~hold_sda_i;
   ////////////////////////////////////////////////////////////////////////////
   // Waits two high clock cycles under a low data line, then grabs the clock
   always_comb
   begin
      next_high_cnt = high_cnt;
      next_bump     = bump;
      if (!bump_scl_i)
      begin
         next_high_cnt = 2'h0;
         next_bump     = 1'b0;
      end
      else if (high_cnt == 2'h2)
         next_bump = 1'b1;
      else if (scl_o && !sda_o)
         next_high_cnt = high_cnt + 2'h1;
   end
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         high_cnt <= 2'h0;
         bump     <= 1'b0;
      end
      else
      begin
         high_cnt <= next_high_cnt;
         bump     <= next_bump;
      end
   end
endmodule
`default_nettype wire

// ==== test_i2c_master_brg_stop_collision.sv ====
// Bench: register access, stop with and without collisions, clock stretch,
// and a buffered SPI-mode transfer checked on the wire.
// Assumes ibc_pkg, ibc_master and ibc_peer are compiled before it.
`default_nettype none
module test_i2c_master_brg_stop_collision;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0]  RLD_I2C = 8'h03;
   localparam logic [7:0]  RLD_SPI = 8'h01;
   localparam logic [7:0]  NOWHERE = 8'h20;
   localparam logic [7:0]  EN      = 8'h01 << ibc_pkg::CTL1_EN_BIT;
   localparam logic [7:0]  STOPREQ = 8'h01 << ibc_pkg::CTL2_STOP_BIT;
   localparam logic [31:0] WORD    = 32'ha53c_f00f;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        scl_d, scl_oe, sda_d, sda_oe, scl_line, sda_line;
   logic        hold_scl = 1'b0;
   logic        hold_sda = 1'b0;
   logic        bump_scl = 1'b0;
   logic        spi_on = 1'b0;
   logic [31:0] spi_bits = 32'h0;
   logic [31:0] rd;
   logic        err;
   logic        last;
   int          n_bits = 0;
   int          n;
   realtime     t_rise [2];
   int          miscompares = 0;
   int          n_compared = 0;
   always #4 clk_i = ~clk_i;
   ibc_master #(.DATA_W(8), .BUF_DEPTH(2)) u_ibc_master (.clk_i(clk_i), .rst_i(rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .scl_i(scl_line), .scl_o(scl_d), .scl_oe_o(scl_oe),
      .sda_i(sda_line), .sda_o(sda_d), .sda_oe_o(sda_oe));
   ibc_peer u_ibc_peer (.clk_i(clk_i), .rst_i(rst_i), .scl_d_i(scl_d), .scl_oe_i(scl_oe),
      .sda_d_i(sda_d), .sda_oe_i(sda_oe), .hold_scl_i(hold_scl), .hold_sda_i(hold_sda),
      .bump_scl_i(bump_scl), .scl_o(scl_line), .sda_o(sda_line));
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One APB transfer; entered just after a rising edge, leaves one idle edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      // Ready, read data and error are taken at the rising edge that ends the access
      @(posedge clk_i);
      while (pready !== 1'b1 && k < 5000)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k == 5000)
         chk(32'h0, 32'h1, "ready never came");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, rd, err);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp, what);
   endtask
   task automatic wait_flags();
      int k;
      k = 0;
      rd = 32'h0;
      while (rd[1:0] == 2'b00 && k < 300)
      begin
         apb(1'b0, ibc_pkg::ADDR_FLAGS, 32'h0, rd, err);
         k++;
      end
   endtask
   task automatic pins_released();
      @(negedge clk_i);
      chk({30'h0, scl_oe, sda_oe}, 32'h0, "lines released");
      @(posedge clk_i);
   endtask
   task automatic clear_flags();
      repeat (20) @(posedge clk_i);
      wr(ibc_pkg::ADDR_FLAGS, 8'h07);
      rdc(ibc_pkg::ADDR_FLAGS, 32'h0, "flags cleared");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Bits sampled on rising clock edges, MSB first
   always @(posedge scl_line)
      if (spi_on)
      begin
         spi_bits <= {spi_bits[30:0], sda_line};
         if (n_bits < 2)
            t_rise[n_bits] <= $realtime;
         n_bits <= n_bits + 1;
      end
   initial
   begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      $display("BAD %0t watchdog expired", $time);
      report_and_stop();
   end
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 32; a += 4)
         rdc(8'(a), {24'h0, ibc_pkg::RST_VAL}, "reset value");
      apb(1'b1, NOWHERE, 32'h5a, rd, err);
      chk({31'h0, err}, 32'h1, "unmapped write error");
      apb(1'b0, NOWHERE, 32'h0, rd, err);
      chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
      wr(ibc_pkg::ADDR_MASK, 8'h5a);
      rdc(ibc_pkg::ADDR_MASK, 32'h5a, "mask read back");
      wr(ibc_pkg::ADDR_RELOAD, RLD_I2C);
      rdc(ibc_pkg::ADDR_RELOAD, {24'h0, RLD_I2C}, "reload read back");
      wr(ibc_pkg::ADDR_CTL1, EN | {4'h0, ibc_pkg::MODE_I2C_MASTER});
      // Data held low by another party past the data release
      hold_sda <= 1'b1;
      wr(ibc_pkg::ADDR_CTL2, STOPREQ);
      wait_flags();
      chk({30'h0, rd[1:0]}, 32'h1, "data collision flag");
      pins_released();
      rdc(ibc_pkg::ADDR_CTL2, 32'h0, "stop request cleared");
      hold_sda <= 1'b0;
      clear_flags();
      // Clock stretched, then pulled low before data rises
      hold_scl <= 1'b1;
      bump_scl <= 1'b1;
      wr(ibc_pkg::ADDR_CTL2, STOPREQ);
      repeat (20) @(posedge clk_i);
      hold_scl <= 1'b0;
      wait_flags();
      chk({30'h0, rd[1:0]}, 32'h1, "clock collision flag");
      pins_released();
      rdc(ibc_pkg::ADDR_CTL2, 32'h0, "stop request cleared");
      bump_scl <= 1'b0;
      clear_flags();
      // Clean stop after a long stretch: count starts only at clock high
      hold_scl <= 1'b1;
      wr(ibc_pkg::ADDR_CTL2, STOPREQ);
      // Buffer write while the stop runs must be dropped and flagged
      wr(ibc_pkg::ADDR_BUF, 8'h99);
      repeat (40) @(posedge clk_i);
      @(negedge clk_i);
      chk({30'h0, sda_line, sda_oe}, 32'h1, "data driven low in stretch");
      @(posedge clk_i);
      hold_scl <= 1'b0;
      n = 0;
      while (sda_line !== 1'b1 && n < 100)
      begin
         @(negedge clk_i);
         n++;
      end
      chk({31'h0, n >= 2 * (RLD_I2C + 1) && n <= 2 * (RLD_I2C + 1) + 3}, 32'h1,
          "data release delay");
      @(posedge clk_i);
      wait_flags();
      chk({29'h0, rd[2:0]}, 32'h6, "port event and write collision flags");
      apb(1'b0, ibc_pkg::ADDR_STATUS, 32'h0, rd, err);
      chk({30'h0, rd[ibc_pkg::STAT_STOP_BIT], rd[ibc_pkg::STAT_BF_BIT]}, 32'h2,
          "stop seen, buffer empty");
      rdc(ibc_pkg::ADDR_CTL2, 32'h0, "stop request cleared");
      clear_flags();
      // SPI master: four bytes through the two-entry buffer
      wr(ibc_pkg::ADDR_RELOAD, RLD_SPI);
      wr(ibc_pkg::ADDR_CTL1, EN | {4'h0, ibc_pkg::MODE_SPI_MASTER});
      spi_on <= 1'b1;
      for (int i = 3; i >= 0; i--)
         wr(ibc_pkg::ADDR_BUF, WORD[8 * i +: 8]);
      n = 0;
      rd = 32'h5;
      while ((rd[2] | rd[0]) !== 1'b0 && n < 300)
      begin
         apb(1'b0, ibc_pkg::ADDR_STATUS, 32'h0, rd, err);
         n++;
      end
      repeat (20) @(posedge clk_i);
      chk(32'(n_bits), 32'd32, "bits on the wire");
      chk(spi_bits, WORD, "serial data");
      chk({31'h0, (t_rise[1] - t_rise[0]) == 32.0 * (RLD_SPI + 1)}, 32'h1,
          "serial clock period");
      last = scl_line;
      repeat (40) @(posedge clk_i);
      chk({30'h0, scl_line, 32'(n_bits) == 32'd32}, {30'h0, last, 1'b1},
          "clock stopped");
      report_and_stop();
   end
endmodule
`default_nettype wire
